// *** hdl/ice_evaluator.sv ***
// Input condition evaluator: one selected source compared with a threshold, or a binary input passed through.
// Assumes synchronous source inputs, one mclk domain, plain register port.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "ice_params.svh"

module ice_evaluator #(
	parameter int DW = 16,
	parameter int NCH = 8,
	parameter int NTMR = 16,
	parameter int TICK_CYC = `ICE_TICK_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Sources
	input wire logic [NCH*DW-1:0] analog_in,
	input wire logic analog_valid,
	input wire logic [NCH-1:0] binary_in,
	input wire logic [NCH*DW-1:0] count_in,
	input wire logic [NCH*DW-1:0] rate_in,
	// To logic stage
	output logic cond_result,
	output logic cond_valid
);
	localparam int CW = $clog2(NCH);
	localparam int TCW = $clog2(TICK_CYC + 1);

	// ======================================================================
	// State
	typedef struct packed {
		logic [31:0] mode_reg;
		logic [31:0] thresh_reg;
		logic [31:0] scale_in_reg;
		logic [31:0] scale_out_reg;
		logic [NTMR-1:0] run_reg;
		logic [3:0] tsel_reg;
		logic [NCH*DW-1:0] prev_reg;
		logic [TCW-1:0] tick_reg;
		logic [NTMR*32-1:0] tmr_reg;
		logic result_reg;
		logic valid_reg;
		logic [31:0] rdata_reg;
	} ice_state_s;

	ice_state_s s_reg, s_next;

	// Decoded fields
	ice_pkg::ice_mode_e mode;
	ice_pkg::ice_op_e op;
	logic [CW-1:0] chan;
	logic tick;
	logic [3:0] tidx;
	logic [31:0] tcnt;
	logic signed [47:0] sample, prev, range_w, dev, lhs;
	logic signed [47:0] thr, n1, m1, n2, m2, scaled;
	logic hit;
	logic [NTMR*32-1:0] tmr_next;

	// ======================================================================
	// Tick decoded outside the next-state process: the timer loop reads it
	assign tick = (s_reg.tick_reg == TCW'(TICK_CYC - 1));

	// Timers, one per index, free counters while started
	genvar g;
	generate
		for (g = 0; g < NTMR; g++) begin : g_tmr
			always_comb begin
				tmr_next[g*32 +: 32] = s_reg.tmr_reg[g*32 +: 32];
				if (s_reg.run_reg[g] && tick) begin
					tmr_next[g*32 +: 32] =
						s_reg.tmr_reg[g*32 +: 32] + 32'h1;
				end
			end
		end
	endgenerate

	// Comparator shared by the level, count, rate and timer compares; deviation uses its own dev > thr
	function automatic logic cmp(input logic signed [47:0] a,
		input logic signed [47:0] b, input ice_pkg::ice_op_e o);
		case (o)
			ice_pkg::ICE_OP_GE: cmp = (a >= b);
			ice_pkg::ICE_OP_EQ: cmp = (a == b);
			ice_pkg::ICE_OP_LE: cmp = (a <= b);
			default: cmp = 1'b0;
		endcase
	endfunction

	// ======================================================================
	// Next state
	always_comb begin
		s_next = s_reg;
		mode = ice_pkg::ice_mode_e'(s_reg.mode_reg[`ICE_MODE_LSB +: 4]);
		op = ice_pkg::ice_op_e'(s_reg.mode_reg[`ICE_OP_LSB +: 2]);
		chan = s_reg.mode_reg[`ICE_CHAN_LSB +: CW];
		tidx = s_reg.mode_reg[`ICE_CHAN_LSB +: 4];
		tcnt = s_reg.tmr_reg[tidx*32 +: 32];
		thr = 48'(signed'(s_reg.thresh_reg));
		n1 = 48'(signed'(s_reg.scale_in_reg[15:0]));
		m1 = 48'(signed'(s_reg.scale_in_reg[31:16]));
		n2 = 48'(signed'(s_reg.scale_out_reg[15:0]));
		m2 = 48'(signed'(s_reg.scale_out_reg[31:16]));
		sample = 48'(signed'({1'b0, analog_in[chan*DW +: DW]}));
		prev = 48'(signed'({1'b0, s_reg.prev_reg[chan*DW +: DW]}));
		range_w = 48'(signed'({1'b0, {DW{1'b1}}}));
		// Percent of full range; magnitude so falls count as well
		dev = ((sample - prev) * 48'sd100) / range_w;
		if (dev < 0) begin
			dev = -dev;
		end
		// Guard against a zero input span, which would divide by zero
		scaled = (m1 == n1) ? n2 :
			n2 + ((sample - n1) * (m2 - n2)) / (m1 - n1);
		lhs = s_reg.mode_reg[`ICE_SCALE_BIT] ? scaled : sample;
		hit = 1'b0;

		// Tick divider for hundredths of a second
		s_next.tick_reg = tick ? '0 : s_reg.tick_reg + TCW'(1);
		s_next.tmr_reg = tmr_next;

		// Condition by mode
		case (mode)
			ice_pkg::ICE_ANALOG_INPUT_MODE: begin
				if (s_reg.mode_reg[`ICE_TYPE_BIT]) begin
					hit = (dev > thr);
				end else begin
					hit = cmp(lhs, thr, op);
				end
			end
			ice_pkg::ICE_BINARY_INPUT_MODE: hit = binary_in[chan];
			ice_pkg::ICE_PULSE_COUNT_MODE: begin
				hit = cmp(48'(signed'({1'b0, count_in[chan*DW +: DW]})),
					thr, op);
			end
			ice_pkg::ICE_PULSE_RATE_MODE: begin
				hit = cmp(48'(signed'({1'b0, rate_in[chan*DW +: DW]})),
					thr, op);
			end
			ice_pkg::ICE_TIMER_MODE: begin
				hit = cmp(48'(signed'({1'b0, tcnt})), thr, op);
			end
			default: hit = 1'b0;
		endcase

		// Evaluate each cycle while the condition is enabled
		s_next.valid_reg = s_reg.mode_reg[`ICE_EVAL_BIT] &&
			(mode != ice_pkg::ICE_IDLE_CONDITION);
		s_next.result_reg = s_next.valid_reg ? hit : 1'b0;

		// Previous sample updates only on a fresh sample
		if (analog_valid) begin
			s_next.prev_reg = analog_in;
		end

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				`ICE_OFF_MODE: s_next.mode_reg = reg_wdata;
				`ICE_OFF_THRESH: s_next.thresh_reg = reg_wdata;
				`ICE_OFF_SCALE_IN: s_next.scale_in_reg = reg_wdata;
				`ICE_OFF_SCALE_OUT: s_next.scale_out_reg = reg_wdata;
				`ICE_OFF_TIMER_CTL: begin
					// Start clears and runs, stop holds the count
					s_next.run_reg[reg_wdata[3:0]] = reg_wdata[4];
					if (reg_wdata[4]) begin
						s_next.tmr_reg[reg_wdata[3:0]*32 +: 32] = '0;
					end
				end
				`ICE_OFF_STATUS: s_next.tsel_reg = reg_wdata[3:0];
				default: ;
			endcase
		end

		// Register reads, data in the following cycle only
		s_next.rdata_reg = '0;
		if (reg_rd) begin
			case (reg_addr)
				`ICE_OFF_MODE: s_next.rdata_reg = s_reg.mode_reg;
				`ICE_OFF_THRESH: s_next.rdata_reg = s_reg.thresh_reg;
				`ICE_OFF_SCALE_IN: s_next.rdata_reg = s_reg.scale_in_reg;
				`ICE_OFF_SCALE_OUT: s_next.rdata_reg = s_reg.scale_out_reg;
				`ICE_OFF_TIMER_CTL: s_next.rdata_reg = 32'(s_reg.run_reg);
				`ICE_OFF_STATUS: begin
					s_next.rdata_reg = {26'h0, s_reg.tsel_reg,
						s_reg.valid_reg, s_reg.result_reg};
				end
				`ICE_OFF_TIMER_VAL: begin
					s_next.rdata_reg = s_reg.tmr_reg[s_reg.tsel_reg*32 +: 32];
				end
				default: s_next.rdata_reg = '0;
			endcase
		end
	end

	// ======================================================================
	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign reg_rdata = s_reg.rdata_reg;
	assign cond_result = s_reg.result_reg;
	assign cond_valid = s_reg.valid_reg;

	// ======================================================================
	// Checks
	// Result and valid are flops: each check but result_valid_a looks one edge after its cause
	idle_gives_false_a: assert property (
		@(posedge mclk) disable iff (rst)
		(mode == ice_pkg::ICE_IDLE_CONDITION) |=> !cond_result)
		else $error("idle condition gave true");
	binary_follow_a: assert property (
		@(posedge mclk) disable iff (rst)
		(mode == ice_pkg::ICE_BINARY_INPUT_MODE && s_next.valid_reg)
		|=> cond_result == $past(binary_in[chan]))
		else $error("binary result does not follow input");
	count_compare_a: assert property (
		@(posedge mclk) disable iff (rst)
		(mode == ice_pkg::ICE_PULSE_COUNT_MODE && s_next.valid_reg &&
		op == ice_pkg::ICE_OP_GE &&
		48'(signed'({1'b0, count_in[chan*DW +: DW]})) >= thr)
		|=> cond_result)
		else $error("count ge not reported");
	rate_compare_a: assert property (
		@(posedge mclk) disable iff (rst)
		(mode == ice_pkg::ICE_PULSE_RATE_MODE && s_next.valid_reg &&
		op == ice_pkg::ICE_OP_LE &&
		48'(signed'({1'b0, rate_in[chan*DW +: DW]})) > thr)
		|=> !cond_result)
		else $error("rate le true above threshold");
	raw_equal_a: assert property (
		@(posedge mclk) disable iff (rst)
		(mode == ice_pkg::ICE_ANALOG_INPUT_MODE && s_next.valid_reg &&
		!s_reg.mode_reg[`ICE_TYPE_BIT] && op == ice_pkg::ICE_OP_EQ &&
		lhs != thr) |=> !cond_result)
		else $error("raw equal true on mismatch");
	// Unscaled level must be the sample itself
	raw_match_a: assert property (
		@(posedge mclk) disable iff (rst)
		(mode == ice_pkg::ICE_ANALOG_INPUT_MODE && s_next.valid_reg &&
		!s_reg.mode_reg[`ICE_TYPE_BIT] && !s_reg.mode_reg[`ICE_SCALE_BIT] &&
		op == ice_pkg::ICE_OP_EQ && sample == thr) |=> cond_result)
		else $error("raw level match not reported");
	// Scaled value, not the raw sample, meets an engineering threshold
	scaled_match_a: assert property (
		@(posedge mclk) disable iff (rst)
		(mode == ice_pkg::ICE_ANALOG_INPUT_MODE && s_next.valid_reg &&
		!s_reg.mode_reg[`ICE_TYPE_BIT] && s_reg.mode_reg[`ICE_SCALE_BIT] &&
		op == ice_pkg::ICE_OP_EQ && scaled == thr) |=> cond_result)
		else $error("scaled level match not reported");
	dev_result_a: assert property (
		@(posedge mclk) disable iff (rst)
		(mode == ice_pkg::ICE_ANALOG_INPUT_MODE && s_next.valid_reg &&
		s_reg.mode_reg[`ICE_TYPE_BIT]) |=> cond_result == $past(dev > thr))
		else $error("deviation result wrong");
	tick_period_a: assert property (
		@(posedge mclk) disable iff (rst)
		tick |=> !tick [*2])
		else $error("timer tick too frequent");
	// Timer checks follow the timer that the mode selects, so they see use
	timer_count_a: assert property (
		@(posedge mclk) disable iff (rst)
		(tick && s_reg.run_reg[tidx] && !reg_wr)
		|=> tcnt == $past(tcnt) + 32'h1)
		else $error("timer did not advance");
	timer_stall_a: assert property (
		@(posedge mclk) disable iff (rst)
		(!(tick && s_reg.run_reg[tidx]) && !reg_wr) |=> $stable(tcnt))
		else $error("timer moved without a tick");
	timer_clear_a: assert property (
		@(posedge mclk) disable iff (rst)
		(reg_wr && reg_addr == `ICE_OFF_TIMER_CTL && reg_wdata[4] &&
		reg_wdata[3:0] == tidx) |=> tcnt == 32'h0 && s_reg.run_reg[tidx])
		else $error("timer start did not clear");
	timer_hold_a: assert property (
		@(posedge mclk) disable iff (rst)
		(mode == ice_pkg::ICE_TIMER_MODE && s_next.valid_reg && !hit)
		|=> !cond_result)
		else $error("timer result high early");
	timer_fire_a: assert property (
		@(posedge mclk) disable iff (rst)
		(mode == ice_pkg::ICE_TIMER_MODE && s_next.valid_reg &&
		op == ice_pkg::ICE_OP_GE && 48'(signed'({1'b0, tcnt})) >= thr)
		|=> cond_result)
		else $error("timer result low after threshold");
	valid_gate_a: assert property (
		@(posedge mclk) disable iff (rst)
		!s_reg.mode_reg[`ICE_EVAL_BIT] |=> !cond_valid && !cond_result)
		else $error("result valid while disabled");
	valid_on_a: assert property (
		@(posedge mclk) disable iff (rst)
		(s_reg.mode_reg[`ICE_EVAL_BIT] && mode != ice_pkg::ICE_IDLE_CONDITION)
		|=> cond_valid)
		else $error("enabled condition not valid");
	result_valid_a: assert property (
		@(posedge mclk) disable iff (rst)
		cond_result |-> cond_valid)
		else $error("result true while not valid");
	status_read_a: assert property (
		@(posedge mclk) disable iff (rst)
		(reg_rd && reg_addr == `ICE_OFF_STATUS)
		|=> reg_rdata[1:0] == $past({cond_valid, cond_result}))
		else $error("status read back wrong");
	read_data_a: assert property (
		@(posedge mclk) disable iff (rst)
		(reg_rd && reg_addr == `ICE_OFF_THRESH)
		|=> reg_rdata == $past(s_reg.thresh_reg))
		else $error("threshold read back wrong");

	// Main scenarios the bench is meant to reach
	timer_fire_c: cover property (@(posedge mclk) disable iff (rst)
		mode == ice_pkg::ICE_TIMER_MODE && !cond_result ##1 cond_result);
	binary_true_c: cover property (@(posedge mclk) disable iff (rst)
		mode == ice_pkg::ICE_BINARY_INPUT_MODE && cond_result);
	scaled_true_c: cover property (@(posedge mclk) disable iff (rst)
		s_reg.mode_reg[`ICE_SCALE_BIT] && cond_result);
	dev_true_c: cover property (@(posedge mclk) disable iff (rst)
		mode == ice_pkg::ICE_ANALOG_INPUT_MODE &&
		s_reg.mode_reg[`ICE_TYPE_BIT] && cond_result);
	count_equal_c: cover property (@(posedge mclk) disable iff (rst)
		mode == ice_pkg::ICE_PULSE_COUNT_MODE && op == ice_pkg::ICE_OP_EQ &&
		cond_result);
endmodule // ice_evaluator

// *** hdl/ice_params.svh ***
// Constants for the input condition evaluator: offsets, fields, resets, timing.
// Assumes a 40 MHz mclk and a plain one-cycle register port.
`ifndef ICE_PARAMS_SVH
`define ICE_PARAMS_SVH

// ==========================================================================
// Register offsets (word index on the plain port)
`define ICE_OFF_MODE 4'h0
`define ICE_OFF_THRESH 4'h1
`define ICE_OFF_SCALE_IN 4'h2
`define ICE_OFF_SCALE_OUT 4'h3
`define ICE_OFF_TIMER_CTL 4'h4
`define ICE_OFF_STATUS 4'h5
`define ICE_OFF_TIMER_VAL 4'h6

// ==========================================================================
// Field positions of the mode register
`define ICE_MODE_LSB 0
`define ICE_OP_LSB 4
`define ICE_TYPE_BIT 6
`define ICE_SCALE_BIT 7
`define ICE_CHAN_LSB 8
`define ICE_EVAL_BIT 12

// ==========================================================================
// Reset values
`define ICE_MODE_RST 32'h0000_0000
`define ICE_THRESH_RST 32'h0000_0000

// ==========================================================================
// Timing: timer tick of 0.01 s
`define ICE_TICK_NS 10000000
`define ICE_CLK_NS 25
`define ICE_TICK_CYC (`ICE_TICK_NS / `ICE_CLK_NS)

`endif

// *** hdl/ice_pkg.sv ***
// Types shared by the input condition evaluator.
// Assumes the params header is included by users that need numbers.
package ice_pkg;
	// Input modes of the condition stage
	typedef enum logic [3:0] {
		ICE_IDLE_CONDITION = 4'h0,
		ICE_ANALOG_INPUT_MODE = 4'h1,
		ICE_BINARY_INPUT_MODE = 4'h2,
		ICE_PULSE_COUNT_MODE = 4'h3,
		ICE_PULSE_RATE_MODE = 4'h4,
		ICE_TIMER_MODE = 4'h5
	} ice_mode_e;
	// Comparison operators
	typedef enum logic [1:0] {
		ICE_OP_GE = 2'h0,
		ICE_OP_EQ = 2'h1,
		ICE_OP_LE = 2'h2
	} ice_op_e;
endpackage

// *** tb/ice_src_model.sv ***
// Source channel model: analog, binary, count and rate inputs.
// Assumes the bench issues set commands on mclk, one per cycle.
`timescale 1ns/1ps

module ice_src_model (
	// Clock
	input wire logic mclk,
	// Set command from the bench
	input wire logic set_stb,
	input wire logic [1:0] set_kind,
	input wire logic [2:0] set_chan,
	input wire logic [15:0] set_val,
	input wire logic set_fresh,
	// Channel outputs
	output logic [127:0] analog_in,
	output logic analog_valid,
	output logic [7:0] binary_in,
	output logic [127:0] count_in,
	output logic [127:0] rate_in
);
	// ======================================================================
	// Channels
	// Values hold until set again; the fresh flag lasts one cycle only
	initial begin
		analog_in = '0;
		analog_valid = 1'b0;
		binary_in = '0;
		count_in = '0;
		rate_in = '0;
	end
	always @(posedge mclk) begin
		analog_valid <= set_stb && set_fresh;
		if (set_stb) begin
			case (set_kind)
				2'h0: analog_in[set_chan*16 +: 16] <= set_val;
				2'h1: binary_in[set_chan] <= set_val[0];
				2'h2: count_in[set_chan*16 +: 16] <= set_val;
				default: rate_in[set_chan*16 +: 16] <= set_val;
			endcase
		end
	end
endmodule // ice_src_model

// *** tb/input_condition_evaluator_test.sv ***
// Bench for the input condition evaluator with a source channel model.
// Assumes a 4-cycle timer tick so timer runs stay short.
`timescale 1ns/1ps
`include "ice_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end

module input_condition_evaluator_test;
	// ======================================================================
	// Signals
	logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, set_stb = 0;
	logic set_fresh = 0, cond_result, cond_valid, analog_valid;
	logic [3:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, d;
	logic [1:0] set_kind = 0;
	logic [2:0] set_chan = 0;
	logic [15:0] set_val = 0;
	logic [127:0] analog_in, count_in, rate_in;
	logic [7:0] binary_in;
	int fails = 0, n_tests = 0, i;
	typedef ice_pkg::ice_mode_e m_e;
	typedef ice_pkg::ice_op_e o_e;

	always #12.5 mclk = ~mclk;

	ice_src_model SRC (.mclk(mclk), .set_stb(set_stb), .set_kind(set_kind),
		.set_chan(set_chan), .set_val(set_val), .set_fresh(set_fresh),
		.analog_in(analog_in), .analog_valid(analog_valid),
		.binary_in(binary_in), .count_in(count_in), .rate_in(rate_in));
	ice_evaluator #(.TICK_CYC(4)) DUT (.mclk(mclk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .analog_in(analog_in),
		.analog_valid(analog_valid), .binary_in(binary_in),
		.count_in(count_in), .rate_in(rate_in),
		.cond_result(cond_result), .cond_valid(cond_valid));

	// ======================================================================
	// Bus, source and check tasks
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 0;
	endtask
	// Read data is only valid in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		reg_rd <= 1; reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask
	task automatic src(input logic [1:0] k, input logic [2:0] c,
		input logic [15:0] v, input logic f);
		@(posedge mclk);
		set_stb <= 1; set_kind <= k; set_chan <= c; set_val <= v;
		set_fresh <= f;
		@(posedge mclk);
		set_stb <= 0;
	endtask
	function automatic logic [31:0] mw(m_e m, o_e o, logic ty, logic sc,
		logic [3:0] ch);
		mw = 32'h0;
		mw[`ICE_MODE_LSB +: 4] = m;
		mw[`ICE_OP_LSB +: 2] = o;
		mw[`ICE_TYPE_BIT] = ty;
		mw[`ICE_SCALE_BIT] = sc;
		mw[`ICE_CHAN_LSB +: 4] = ch;
		mw[`ICE_EVAL_BIT] = 1'b1;
	endfunction
	// Level result: allow the two-edge config latency to settle first
	task automatic cond(input logic e, input logic v);
		repeat (4) @(posedge mclk);
		#1;
		`CHK("cond_result", e, cond_result)
		`CHK("cond_valid", v, cond_valid)
	endtask

	// ======================================================================
	// Scenarios
	task automatic t_reset();
		cond(1'b0, 1'b0);
		rd(`ICE_OFF_MODE); `CHK("mode_rst", `ICE_MODE_RST, d)
		rd(4'hf); `CHK("unmapped", 32'h0, d)
		wr(`ICE_OFF_THRESH, 32'h0000_1234);
		rd(`ICE_OFF_THRESH); `CHK("thresh", 32'h0000_1234, d)
		$display("test reset done");
	endtask
	task automatic t_binary();
		wr(`ICE_OFF_MODE, mw(ice_pkg::ICE_BINARY_INPUT_MODE, o_e'(0), 0, 0, 7));
		src(1, 7, 1, 0); cond(1'b1, 1'b1);
		rd(`ICE_OFF_STATUS); `CHK("status", 2'h3, d[1:0])
		src(1, 7, 0, 0); cond(1'b0, 1'b1);
		$display("test binary done");
	endtask
	// Every operator against thresholds just below, at and above the count
	task automatic t_count();
		src(2, 0, 100, 0);
		for (int o = 0; o < 3; o++) begin
			wr(`ICE_OFF_MODE, mw(ice_pkg::ICE_PULSE_COUNT_MODE, o_e'(o), 0, 0, 0));
			for (int k = 0; k < 3; k++) begin
				wr(`ICE_OFF_THRESH, 99 + k);
				cond(o == 0 ? k <= 1 : o == 1 ? k == 1 : k >= 1, 1'b1);
			end
		end
		$display("test count done");
	endtask
	task automatic t_rate();
		src(3, 1, 50, 0);
		wr(`ICE_OFF_MODE, mw(ice_pkg::ICE_PULSE_RATE_MODE, ice_pkg::ICE_OP_LE,
			0, 0, 1));
		wr(`ICE_OFF_THRESH, 50); cond(1'b1, 1'b1);
		wr(`ICE_OFF_THRESH, 49); cond(1'b0, 1'b1);
		$display("test rate done");
	endtask
	// Input 4..20 scaled onto 0..10: level 12 reads as 5 units
	task automatic t_analog();
		src(0, 2, 12, 0);
		wr(`ICE_OFF_SCALE_IN, {16'd20, 16'd4});
		wr(`ICE_OFF_SCALE_OUT, {16'd10, 16'd0});
		wr(`ICE_OFF_MODE, mw(ice_pkg::ICE_ANALOG_INPUT_MODE, ice_pkg::ICE_OP_EQ,
			0, 0, 2));
		wr(`ICE_OFF_THRESH, 12); cond(1'b1, 1'b1);
		wr(`ICE_OFF_MODE, mw(ice_pkg::ICE_ANALOG_INPUT_MODE, ice_pkg::ICE_OP_EQ,
			0, 1, 2));
		cond(1'b0, 1'b1);
		wr(`ICE_OFF_THRESH, 5); cond(1'b1, 1'b1);
		$display("test analog done");
	endtask
	// Step of 16384 over full range 65535 is 25 percent
	task automatic t_dev();
		wr(`ICE_OFF_MODE, mw(ice_pkg::ICE_ANALOG_INPUT_MODE, o_e'(0), 1, 0, 5));
		src(0, 5, 0, 1);
		src(0, 5, 16'h4000, 0);
		wr(`ICE_OFF_THRESH, 20); cond(1'b1, 1'b1);
		wr(`ICE_OFF_THRESH, 25); cond(1'b0, 1'b1);
		$display("test deviation done");
	endtask
	// Five hundredths at four cycles each: about 20 cycles to go high
	task automatic t_timer();
		wr(`ICE_OFF_MODE, mw(ice_pkg::ICE_TIMER_MODE, o_e'(0), 0, 0, 15));
		wr(`ICE_OFF_THRESH, 5);
		wr(`ICE_OFF_TIMER_CTL, 32'h1f);
		#1 `CHK("timer_low", 1'b0, cond_result)
		// Sample a settled output, one step after each edge
		for (i = 0; i < 200 && cond_result !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		// A timeout counts here; the run still ends in the verdict
		if (i == 200) begin
			fails++;
		end
		`CHK("timer_delay", 1'b1, i >= 15 && i <= 30)
		wr(`ICE_OFF_STATUS, 32'hf);
		rd(`ICE_OFF_TIMER_VAL); `CHK("timer_val", 1'b1, d >= 5)
		$display("test timer done");
	endtask

	// ======================================================================
	// Verdict
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard
	initial begin
		#1000000;
		fails++;
		results();
	end

	initial begin
		repeat (2) @(posedge mclk);
		rst <= 0;
		t_reset();
		t_binary();
		t_count();
		t_rate();
		t_analog();
		t_dev();
		t_timer();
		results();
	end
endmodule // input_condition_evaluator_test
